// [aocr_defines.vh]
/*
 * constants for the converter output configuration register bank:
 * register addresses, reset values, field positions and encodings.
 * assumes it is included by its bare name from the design files.
 */
`ifndef AOCR_DEFINES_VH
`define AOCR_DEFINES_VH

// ****************************************************************
// register addresses
// ****************************************************************
`define AOCR_ADDR_TEST 8'h0D
`define AOCR_ADDR_OFFSET 8'h10
`define AOCR_ADDR_OUTCFG 8'h14
`define AOCR_ADDR_PHASE 8'h16
`define AOCR_ADDR_REF 8'h18
`define AOCR_ADDR_UPDATE 8'hFF

// ****************************************************************
// reset values
// ****************************************************************
`define AOCR_RST_TEST 8'h00
`define AOCR_RST_OFFSET 8'h00
`define AOCR_RST_OUTCFG 8'h00
`define AOCR_RST_PHASE 8'h00
`define AOCR_RST_REF 8'hC0

// ****************************************************************
// field positions
// ****************************************************************
`define AOCR_TEST_MODE_MSB 2
`define AOCR_TEST_MODE_LSB 0
`define AOCR_TEST_SHORT_RST 4
`define AOCR_TEST_LONG_RST 5
`define AOCR_OFFSET_MSB 5
`define AOCR_OUT_FMT_MSB 1
`define AOCR_OUT_FMT_LSB 0
`define AOCR_OUT_INVERT 2
`define AOCR_OUT_DISABLE 4
`define AOCR_OUT_DRV_MSB 7
`define AOCR_OUT_DRV_LSB 6
`define AOCR_PHASE_INV 7
`define AOCR_REF_MSB 7
`define AOCR_REF_LSB 6
`define AOCR_UPDATE_XFER 0

// ****************************************************************
// encodings
// ****************************************************************
`define AOCR_FMT_OFFBIN 2'h0
`define AOCR_FMT_TWOS 2'h1
`define AOCR_FMT_GRAY 2'h2
`define AOCR_TP_OFF 3'h0
`define AOCR_TP_MID 3'h1
`define AOCR_TP_PFS 3'h2
`define AOCR_TP_NFS 3'h3
`define AOCR_TP_CHECK 3'h4
`define AOCR_TP_LONG 3'h5
`define AOCR_TP_SHORT 3'h6

// ****************************************************************
// pseudo-random generator seeds (all ones)
// ****************************************************************
`define AOCR_LONG_SEED 23'h7FFFFF
`define AOCR_SHORT_SEED 9'h1FF

`endif

// [aocr_prbs.v]
/*
 * free-running fibonacci pseudo-random generator used for test patterns.
 * assumes a single core clock; held at its seed while hold is high.
 */
`timescale 1ns/1ps

module aocr_prbs #(
  parameter WIDTH = 23,
  parameter TAP = 18,
  parameter [WIDTH-1:0] SEED = {WIDTH{1'b1}}
) (
  input wire i_core_clk,
  input wire i_reset,
  input wire i_hold,
  output wire [WIDTH-1:0] o_state
);

  reg [WIDTH-1:0] lfsr_reg;
  wire feedback;

  // polynomial x^WIDTH + x^TAP + 1
  assign feedback = lfsr_reg[WIDTH-1] ^ lfsr_reg[TAP-1];

  // shift each cycle unless held; the hold keeps the sequence restartable
  always @(posedge i_core_clk) begin
    if (i_reset || i_hold) begin
      lfsr_reg <= SEED;
    end else begin
      lfsr_reg <= {lfsr_reg[WIDTH-2:0], feedback};
    end
  end

  assign o_state = lfsr_reg;

endmodule // aocr_prbs

// [aocr_regbank.v]
/*
 * output configuration register bank of a pipelined converter and the
 * output path it steers: offset trim, test patterns, format, invert,
 * disable and clock polarity. staged registers are written by the serial
 * port engine; settings move to the active copies on the transfer bit.
 * assumes the serial port engine delivers decoded one-cycle write and read
 * strobes on i_core_clk, and that converter samples arrive on that clock.
 */
`timescale 1ns/1ps
`include "aocr_defines.vh"

// Function
// - offset trim adds a signed 6-bit value, -32 to +31, to each sample.
// - output-disable bit 1 turns the data outputs off; 0 drives them while the synchronised enable pin is high.
// - invert bit 1 drives the inverse of every output data bit.
// - format field: 00 offset binary, 01 twos complement, 10 gray.
// - clock polarity bit 1 inverts the data output clock.
// - staged writes take effect only after the transfer bit is set.

module aocr_regbank #(
  parameter DATA_W = 14
) (
  input wire i_core_clk,
  input wire i_reset,
  input wire i_wr_stb,
  input wire i_rd_stb,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  output reg [7:0] o_rdata,
  output reg o_rvalid,
  input wire [DATA_W-1:0] i_sample,
  input wire i_output_enable_pin_n,
  output reg [DATA_W-1:0] o_data,
  output reg o_data_oe,
  output reg o_clk_invert,
  output reg [1:0] o_drive_cfg,
  output reg [1:0] o_ref_divider
);

  // ****************************************************************
  // staged and active registers
  // ****************************************************************
  reg [7:0] test_stage_reg;
  reg [7:0] offset_stage_reg;
  reg [7:0] outcfg_stage_reg;
  reg [7:0] phase_stage_reg;
  reg [7:0] ref_stage_reg;
  reg [7:0] test_act_reg;
  reg [7:0] offset_act_reg;
  reg [7:0] outcfg_act_reg;
  reg [7:0] phase_act_reg;
  reg [7:0] ref_act_reg;
  reg oe_pin_meta_reg;
  reg oe_pin_sync_reg;
  reg [DATA_W-1:0] data_next;
  reg [DATA_W-1:0] coded;
  reg [DATA_W-1:0] pattern;
  reg signed [DATA_W+1:0] trimmed;
  reg [DATA_W-1:0] clamped;
  wire xfer;
  wire [22:0] long_state;
  wire [8:0] short_state;
  wire [2:0] tp_mode;
  wire [1:0] fmt;

  localparam signed [DATA_W+1:0] MAX_CODE = {2'b00, {DATA_W{1'b1}}};

  assign xfer = i_wr_stb && (i_addr == `AOCR_ADDR_UPDATE) && i_wdata[`AOCR_UPDATE_XFER];
  assign tp_mode = test_act_reg[`AOCR_TEST_MODE_MSB:`AOCR_TEST_MODE_LSB];
  assign fmt = outcfg_act_reg[`AOCR_OUT_FMT_MSB:`AOCR_OUT_FMT_LSB];

  // ****************************************************************
  // register writes and transfer
  // ****************************************************************
  // host writes land in the staged copy only
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      test_stage_reg <= `AOCR_RST_TEST;
      offset_stage_reg <= `AOCR_RST_OFFSET;
      outcfg_stage_reg <= `AOCR_RST_OUTCFG;
      phase_stage_reg <= `AOCR_RST_PHASE;
      ref_stage_reg <= `AOCR_RST_REF;
    end else if (i_wr_stb) begin
      case (i_addr)
        `AOCR_ADDR_TEST: test_stage_reg <= i_wdata;
        `AOCR_ADDR_OFFSET: offset_stage_reg <= i_wdata;
        `AOCR_ADDR_OUTCFG: outcfg_stage_reg <= i_wdata;
        `AOCR_ADDR_PHASE: phase_stage_reg <= i_wdata;
        `AOCR_ADDR_REF: ref_stage_reg <= i_wdata;
        default: ;
      endcase
    end
  end

  // transfer copies all staged values at once so the core never sees a mix
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      test_act_reg <= `AOCR_RST_TEST;
      offset_act_reg <= `AOCR_RST_OFFSET;
      outcfg_act_reg <= `AOCR_RST_OUTCFG;
      phase_act_reg <= `AOCR_RST_PHASE;
      ref_act_reg <= `AOCR_RST_REF;
    end else if (xfer) begin
      test_act_reg <= test_stage_reg;
      offset_act_reg <= offset_stage_reg;
      outcfg_act_reg <= outcfg_stage_reg;
      phase_act_reg <= phase_stage_reg;
      ref_act_reg <= ref_stage_reg;
    end
  end

  // ****************************************************************
  // register reads
  // ****************************************************************
  // reads return the staged copy; transfer bit self-clears and reads 0
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      o_rdata <= 8'h00;
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= i_rd_stb;
      if (i_rd_stb) begin
        case (i_addr)
          `AOCR_ADDR_TEST: o_rdata <= test_stage_reg;
          `AOCR_ADDR_OFFSET: o_rdata <= offset_stage_reg;
          `AOCR_ADDR_OUTCFG: o_rdata <= outcfg_stage_reg;
          `AOCR_ADDR_PHASE: o_rdata <= phase_stage_reg;
          `AOCR_ADDR_REF: o_rdata <= ref_stage_reg;
          default: o_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ****************************************************************
  // pin synchroniser
  // ****************************************************************
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      oe_pin_meta_reg <= 1'b1;
      oe_pin_sync_reg <= 1'b1;
    end else begin
      oe_pin_meta_reg <= i_output_enable_pin_n;
      oe_pin_sync_reg <= oe_pin_meta_reg;
    end
  end

  // ****************************************************************
  // pseudo-random pattern sources
  // ****************************************************************
  aocr_prbs #(
    .WIDTH(23),
    .TAP(18),
    .SEED(`AOCR_LONG_SEED)
  ) u_long_prbs (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_hold(test_act_reg[`AOCR_TEST_LONG_RST]),
    .o_state(long_state)
  );

  aocr_prbs #(
    .WIDTH(9),
    .TAP(5),
    .SEED(`AOCR_SHORT_SEED)
  ) u_short_prbs (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_hold(test_act_reg[`AOCR_TEST_SHORT_RST]),
    .o_state(short_state)
  );

  // ****************************************************************
  // output data path
  // ****************************************************************
  // trim saturates at the code range instead of wrapping, so a large
  // offset never folds full scale into the opposite rail
  always @* begin
    trimmed = $signed({2'b00, i_sample}) +
      $signed({{(DATA_W-4){offset_act_reg[`AOCR_OFFSET_MSB]}},
      offset_act_reg[`AOCR_OFFSET_MSB:0]});
    if (trimmed < 0) begin
      clamped = {DATA_W{1'b0}};
    end else if (trimmed > MAX_CODE) begin
      clamped = {DATA_W{1'b1}};
    end else begin
      clamped = trimmed[DATA_W-1:0];
    end
  end

  // test patterns are offset-binary codes, formatted like real samples
  always @* begin
    case (tp_mode)
      `AOCR_TP_OFF: pattern = clamped;
      `AOCR_TP_MID: pattern = {1'b1, {(DATA_W-1){1'b0}}};
      `AOCR_TP_PFS: pattern = {DATA_W{1'b1}};
      `AOCR_TP_NFS: pattern = {DATA_W{1'b0}};
      `AOCR_TP_CHECK: pattern = {(DATA_W/2){2'b10}};
      `AOCR_TP_LONG: pattern = long_state[DATA_W-1:0];
      `AOCR_TP_SHORT: pattern = {{(DATA_W-9){1'b0}}, short_state};
      default: pattern = clamped;
    endcase
  end

  // format, then optional inversion
  always @* begin
    case (fmt)
      `AOCR_FMT_TWOS: coded = {~pattern[DATA_W-1], pattern[DATA_W-2:0]};
      `AOCR_FMT_GRAY: coded = pattern ^ (pattern >> 1);
      default: coded = pattern;
    endcase
    if (outcfg_act_reg[`AOCR_OUT_INVERT]) begin
      data_next = ~coded;
    end else begin
      data_next = coded;
    end
  end

  // registered outputs; data keeps moving while disabled, only the enable drops
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      o_data <= {DATA_W{1'b0}};
      o_data_oe <= 1'b0;
      o_clk_invert <= 1'b0;
      o_drive_cfg <= 2'b00;
      o_ref_divider <= 2'b11;
    end else begin
      o_data_oe <= ~outcfg_act_reg[`AOCR_OUT_DISABLE] && oe_pin_sync_reg;
      o_data <= data_next;
      o_clk_invert <= phase_act_reg[`AOCR_PHASE_INV];
      o_drive_cfg <= outcfg_act_reg[`AOCR_OUT_DRV_MSB:`AOCR_OUT_DRV_LSB];
      o_ref_divider <= ref_act_reg[`AOCR_REF_MSB:`AOCR_REF_LSB];
    end
  end

endmodule // aocr_regbank

// [aocr_host_model.sv]
/* host model: drives the register strobes of the bank one access at a time.
   assumes one core clock; requests change 1 ns after a rising edge. */
`timescale 1ns/1ps

module aocr_host_model (
  input wire i_core_clk,
  output logic o_wr_stb,
  output logic o_rd_stb,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  input wire [7:0] i_rdata,
  input wire i_rvalid
);
  // ****************************************************************
  // access tasks
  // ****************************************************************
  // idle address and data show the inverse so a stale value is never reused
  initial begin
    o_wr_stb = 1'b0;
    o_rd_stb = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end

  // transfer write at 8'hFF is how staged settings go live
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    #1;
    o_wr_stb = 1'b1;
    o_addr = a;
    o_wdata = d;
    @(posedge i_core_clk);
    #1;
    o_wr_stb = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask

  // answer is taken one edge after the strobe; no answer reads as unknown
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_core_clk);
    #1;
    o_rd_stb = 1'b1;
    o_addr = a;
    @(posedge i_core_clk);
    #1;
    o_rd_stb = 1'b0;
    o_addr = ~a;
    d = i_rvalid ? i_rdata : 8'hxx;
  endtask
endmodule // aocr_host_model

// [aocr_regbank_assertions.sv]
/* port checker of the output configuration register bank.
   assumes one core clock and a synchronous active-high reset. */
`timescale 1ns/1ps

module aocr_regbank_assertions #(
  parameter DATA_W = 14
) (
  input wire i_core_clk,
  input wire i_reset,
  input wire i_wr_stb,
  input wire i_rd_stb,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire [7:0] o_rdata,
  input wire o_rvalid,
  input wire [DATA_W-1:0] i_sample,
  input wire i_output_enable_pin_n,
  input wire [DATA_W-1:0] o_data,
  input wire o_data_oe,
  input wire o_clk_invert,
  input wire [1:0] o_drive_cfg,
  input wire [1:0] o_ref_divider
);
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  wire xfer_w = i_wr_stb && i_addr == 8'hFF && i_wdata[0];
  wire mapped_w = i_addr inside {8'h0D, 8'h10, 8'h14, 8'h16, 8'h18};
  sequence pin_low_held;
    !i_output_enable_pin_n [*4];
  endsequence

  chk_read_answer: assert property (i_rd_stb |=> o_rvalid)
    else $error("read strobe got no answer");
  chk_rvalid_cause: assert property (o_rvalid |-> $past(i_rd_stb))
    else $error("read answer without a strobe");
  chk_unmapped_zero: assert property (i_rd_stb && !mapped_w |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_rdata_hold: assert property (!o_rvalid |-> $stable(o_rdata))
    else $error("read data moved without a read");
  chk_pin_blocks_oe: assert property (pin_low_held |-> !o_data_oe)
    else $error("outputs driven with enable pin low");
  chk_oe_needs_pin: assert property (o_data_oe |-> $past(i_output_enable_pin_n, 3))
    else $error("outputs driven too early after pin rise");
  // settings may only move in the two edges after a transfer write
  chk_config_steady: assert property ($changed({o_clk_invert, o_drive_cfg, o_ref_divider})
    |-> $past(xfer_w, 1) || $past(xfer_w, 2))
    else $error("active setting moved without transfer");
  chk_reset_values: assert property (disable iff (1'b0) $fell(i_reset)
    |-> o_ref_divider == 2'h3 && !o_clk_invert && !o_data_oe)
    else $error("wrong output value after reset");
endmodule // aocr_regbank_assertions

bind aocr_regbank aocr_regbank_assertions #(.DATA_W(DATA_W)) chk (
  .i_core_clk(i_core_clk), .i_reset(i_reset), .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb),
  .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
  .i_sample(i_sample), .i_output_enable_pin_n(i_output_enable_pin_n), .o_data(o_data),
  .o_data_oe(o_data_oe), .o_clk_invert(o_clk_invert), .o_drive_cfg(o_drive_cfg),
  .o_ref_divider(o_ref_divider));

// [adc_output_config_registers_test.sv]
/* self-checking bench of the register bank: register access, transfer,
   test patterns, formats, offset trim and output enables.
   assumes the host model drives the strobes and the bench drives samples. */
`timescale 1ns/1ps

module adc_output_config_registers_test;
  logic i_core_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [13:0] i_sample = 14'h1000;
  logic i_output_enable_pin_n = 1'b1;
  wire wr_stb, rd_stb, o_rvalid, o_data_oe, o_clk_invert;
  wire [7:0] addr, wdata, o_rdata;
  wire [13:0] o_data;
  wire [1:0] o_drive_cfg, o_ref_divider;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [7:0] rd;
  logic [7:0] ra [5] = '{8'h0D, 8'h10, 8'h14, 8'h16, 8'h18};
  logic [7:0] rv [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hC0};
  logic [7:0] wv [5] = '{8'h36, 8'h2A, 8'hD6, 8'h80, 8'h40};
  logic [13:0] pat [5] = '{14'h0000, 14'h2000, 14'h3FFF, 14'h0000, 14'h2AAA};
  logic [13:0] os [5] = '{14'h1000, 14'h1000, 14'h1000, 14'h3FF0, 14'h0010};
  logic [7:0] ov [5] = '{8'h1F, 8'h20, 8'h00, 8'h1F, 8'h20};
  logic [13:0] oe [5] = '{14'h101F, 14'h0FE0, 14'h1000, 14'h3FFF, 14'h0000};

  // ****************************************************************
  // harness
  // ****************************************************************
  always #50 i_core_clk = ~i_core_clk;
  aocr_host_model host (.i_core_clk(i_core_clk), .o_wr_stb(wr_stb), .o_rd_stb(rd_stb),
    .o_addr(addr), .o_wdata(wdata), .i_rdata(o_rdata), .i_rvalid(o_rvalid));
  aocr_regbank #(.DATA_W(14)) dut (.i_core_clk(i_core_clk), .i_reset(i_reset),
    .i_wr_stb(wr_stb), .i_rd_stb(rd_stb), .i_addr(addr), .i_wdata(wdata),
    .o_rdata(o_rdata), .o_rvalid(o_rvalid), .i_sample(i_sample),
    .i_output_enable_pin_n(i_output_enable_pin_n), .o_data(o_data), .o_data_oe(o_data_oe),
    .o_clk_invert(o_clk_invert), .o_drive_cfg(o_drive_cfg), .o_ref_divider(o_ref_divider));

  task automatic print_verdict;
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // run is about three hundred cycles; the ceiling leaves a wide margin for a hang
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_pin(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask

  // new settings reach the outputs on the second edge after the transfer
  task automatic xfer;
    host.write(8'hFF, 8'h01);
    settle(1);
  endtask

  function automatic logic [13:0] fmt_out(input logic [13:0] v, input int f, input int n);
    logic [13:0] r;
    r = (f == 1) ? (v ^ 14'h2000) : (f == 2) ? (v ^ (v >> 1)) : v;
    return (n != 0) ? ~r : r;
  endfunction

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    settle(12);
    i_reset = 1'b0;
    for (int i = 0; i < 5; i++) begin
      host.read(ra[i], rd);
      cmp_reg(rd, rv[i]);
    end
    host.read(8'h20, rd);
    cmp_reg(rd, 8'h00);
    host.read(8'hFF, rd);
    cmp_reg(rd, 8'h00);
    for (int i = 0; i < 5; i++) host.write(ra[i], wv[i]);
    for (int i = 0; i < 5; i++) begin
      host.read(ra[i], rd);
      cmp_reg(rd, wv[i]);
    end
    cmp_pin({15'h0, o_clk_invert}, 16'h0);
    xfer();
    cmp_pin({12'h0, o_drive_cfg, o_ref_divider}, 16'h0D);
    cmp_pin({14'h0, o_clk_invert, o_data_oe}, 16'h2);
    for (int i = 0; i < 5; i++) host.write(ra[i], rv[i]);
    xfer();
    cmp_pin({14'h0, o_clk_invert, o_data_oe}, 16'h1);
    // every fixed pattern through every format, plain and inverted
    for (int m = 1; m < 5; m++)
      for (int f = 0; f < 3; f++)
        for (int n = 0; n < 2; n++) begin
          host.write(8'h0D, 8'(m));
          host.write(8'h14, 8'(f + 4 * n));
          xfer();
          cmp_pin(o_data, fmt_out(pat[m], f, n));
        end
    host.write(8'h0D, 8'h00);
    host.write(8'h14, 8'h00);
    for (int i = 0; i < 5; i++) begin
      i_sample = os[i];
      host.write(8'h10, ov[i]);
      xfer();
      cmp_pin(o_data, oe[i]);
    end
    // generators held at their all-ones seeds, then one free step, then code 7
    i_sample = 14'h1234;
    host.write(8'h10, 8'h00);
    host.write(8'h0D, 8'h25);
    xfer();
    settle(1);
    cmp_pin(o_data, 14'h3FFF);
    host.write(8'h0D, 8'h16);
    xfer();
    settle(1);
    cmp_pin(o_data, 14'h01FF);
    host.write(8'h0D, 8'h06);
    xfer();
    settle(1);
    cmp_pin(o_data, 14'h01FE);
    host.write(8'h0D, 8'h07);
    xfer();
    cmp_pin(o_data, 14'h1234);
    // four low samples so the pin checker sees its whole window
    i_output_enable_pin_n = 1'b0;
    settle(4);
    cmp_pin({15'h0, o_data_oe}, 16'h0);
    i_output_enable_pin_n = 1'b1;
    settle(3);
    cmp_pin({15'h0, o_data_oe}, 16'h1);
    print_verdict();
  end
endmodule // adc_output_config_registers_test
